// ### hdl/rcss_selector.sv
// run command source selector and run/direction decoder
`timescale 1ns/100ps
// Overview of operation
// - source 02 runs on keypad run/stop keys
// - keypad direction 00 forward, 01 reverse
// - output function 59 flags keypad run available
// - drive needs run plus valid frequency
// - source 01 takes terminal forward/reverse inputs
// - function 00 forward, 01 reverse input
// - forward/reverse both or neither means stop
// - reset maps terminal 1 forward, 2 reverse
// - polarity 00 normally open, 01 closed
// - three-wire starts on start edge with stop
// - three-wire stops when stop input drops
// - stop terminal always read normally closed
// - stop function assigned overrides forward/reverse inputs
// - code 21 stop, 22 direction input
// - source 03 takes serial link commands only
// - program variables accepted in terminal mode
// - two selector copies, chosen by motor select
// - source 04 takes option board commands
// - force inputs override selector to keypad/terminal
// - force keypad wins over force terminal
module rcss_selector
    import rcss_pkg::*;
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic [7:0] run_source_select_in,
    input wire logic [7:0] run_source_select_2nd_in,
    input wire logic second_motor_in,
    input wire logic [7:0] keypad_run_direction_in,
    input wire logic keypad_run_key_in,
    input wire logic keypad_stop_key_in,
    input wire logic [6:0] terminal_raw_in,
    input wire logic cfg_write_in,
    input wire logic [2:0] cfg_terminal_in,
    input wire logic [7:0] cfg_function_in,
    input wire logic [7:0] cfg_polarity_in,
    input wire logic prog_forward_in,
    input wire logic prog_reverse_in,
    input wire logic prog_start_in,
    input wire logic prog_stop_in,
    input wire logic prog_direction_in,
    input wire logic serial_run_in,
    input wire logic serial_reverse_in,
    input wire logic option_run_in,
    input wire logic option_reverse_in,
    input wire logic freq_valid_in,
    input wire logic [7:0] output_terminal_function_a_in,
    input wire logic [7:0] output_terminal_function_b_in,
    input wire logic [7:0] output_terminal_function_relay_in,
    output logic run_command_out,
    output logic reverse_out,
    output logic drive_enable_out,
    output logic [2:0] output_terminal_out,
    output logic [2:0] active_source_out
);
    logic [7:0] func_r [RCSS_TERMS];
    logic [7:0] pol_r [RCSS_TERMS];
    logic [6:0] term_act;
    logic [7:0] term_fn [RCSS_TERMS];
    logic fwd_in, rev_in, start3, stop3, dir3, stop3_assigned, force_key, force_term;
    logic [7:0] sel_value;
    rcss_sel_type sel;
    logic key_run_r, key_rev_r, three_run, key_avail;
    logic run_nxt, rev_nxt;

    // terminal configuration table
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            for (int i = 0; i < RCSS_TERMS; i++) begin
                func_r[i] <= RCSS_FN_RST_OTHER;
                pol_r[i] <= RCSS_POL_NO;
            end
            func_r[0] <= RCSS_FN_RST_T1;
            func_r[1] <= RCSS_FN_RST_T2;
        end else if (ce_in && cfg_write_in && (int'(cfg_terminal_in) < RCSS_TERMS)) begin
            func_r[cfg_terminal_in] <= cfg_function_in;
            pol_r[cfg_terminal_in] <= cfg_polarity_in;
        end
    end

    genvar g;
    generate
        for (g = 0; g < RCSS_TERMS; g++) begin : gen_term
            rcss_term_in u_term (
                .clock_in(clock_in),
                .srst_in(srst_in),
                .ce_in(ce_in),
                .raw_in(terminal_raw_in[g]),
                .function_in(func_r[g]),
                .polarity_in(pol_r[g]),
                .active_out(term_act[g]),
                .function_out(term_fn[g])
            );
        end
    endgenerate

    // gather terminal functions; program variables other than stop are ored in below, program stop is inverted and anded
    always_comb begin
        fwd_in = 1'b0;
        rev_in = 1'b0;
        start3 = 1'b0;
        stop3 = 1'b1;
        dir3 = 1'b0;
        stop3_assigned = 1'b0;
        force_key = 1'b0;
        force_term = 1'b0;
        for (int i = 0; i < RCSS_TERMS; i++) begin
            if (term_fn[i] == RCSS_FN_FWD) begin
                fwd_in = fwd_in | term_act[i];
            end else if (term_fn[i] == RCSS_FN_REV) begin
                rev_in = rev_in | term_act[i];
            end else if (term_fn[i] == RCSS_FN_START3) begin
                start3 = start3 | term_act[i];
            end else if (term_fn[i] == RCSS_FN_STOP3) begin
                stop3_assigned = 1'b1;
                stop3 = stop3 & term_act[i];
            end else if (term_fn[i] == RCSS_FN_DIR3) begin
                dir3 = dir3 | term_act[i];
            end else if (term_fn[i] == RCSS_FN_FORCE_KEY) begin
                force_key = force_key | term_act[i];
            end else if (term_fn[i] == RCSS_FN_FORCE_TERM) begin
                force_term = force_term | term_act[i];
            end
        end
        if (!stop3_assigned) begin
            stop3 = 1'b0;
        end
    end

    // selector copy per motor set, then force overrides
    always_comb begin
        sel_value = second_motor_in ? run_source_select_2nd_in : run_source_select_in;
        if (force_key) begin
            sel = RCSS_SEL_KEYPAD;
        end else if (force_term) begin
            sel = RCSS_SEL_TERMINAL;
        end else if (sel_value == RCSS_SRC_KEYPAD) begin
            sel = RCSS_SEL_KEYPAD;
        end else if (sel_value == RCSS_SRC_TERMINAL) begin
            sel = RCSS_SEL_TERMINAL;
        end else if (sel_value == RCSS_SRC_SERIAL) begin
            sel = RCSS_SEL_SERIAL;
        end else if (sel_value == RCSS_SRC_OPTION) begin
            sel = RCSS_SEL_OPTION;
        end else begin
            sel = RCSS_SEL_NONE;
        end
    end

    // keypad run latch; stop key wins over a run key in the same cycle
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            key_run_r <= 1'b0;
            key_rev_r <= 1'b0;
        end else if (ce_in) begin
            if (sel != RCSS_SEL_KEYPAD || keypad_stop_key_in) begin
                key_run_r <= 1'b0;
            end else if (keypad_run_key_in) begin
                key_run_r <= 1'b1;
                key_rev_r <= (keypad_run_direction_in == RCSS_DIR_REV);
            end
        end
    end

    // program stop variable is active high: 1 stops the run, like a closed stop contact
    rcss_three_wire u_three (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .enable_in(sel == RCSS_SEL_TERMINAL && stop3_assigned),
        .start_in(start3 | prog_start_in),
        .stop_active_in(stop3 & ~prog_stop_in),
        .run_out(three_run)
    );

    always_comb begin
        run_nxt = 1'b0;
        rev_nxt = 1'b0;
        case (sel)
            RCSS_SEL_KEYPAD: begin
                run_nxt = key_run_r;
                rev_nxt = key_rev_r;
            end
            RCSS_SEL_TERMINAL: begin
                if (stop3_assigned) begin
                    run_nxt = three_run;
                    rev_nxt = dir3 | prog_direction_in;
                end else begin
                    run_nxt = (fwd_in | prog_forward_in) ^ (rev_in | prog_reverse_in);
                    rev_nxt = rev_in | prog_reverse_in;
                end
            end
            RCSS_SEL_SERIAL: begin
                run_nxt = serial_run_in;
                rev_nxt = serial_reverse_in;
            end
            RCSS_SEL_OPTION: begin
                run_nxt = option_run_in;
                rev_nxt = option_reverse_in;
            end
            default: begin
                run_nxt = 1'b0;
                rev_nxt = 1'b0;
            end
        endcase
    end

    // keypad run is available when keypad owns the source, no run is active and the stop key is released
    assign key_avail = (sel == RCSS_SEL_KEYPAD) && !key_run_r && !keypad_stop_key_in;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            run_command_out <= 1'b0;
            reverse_out <= 1'b0;
            drive_enable_out <= 1'b0;
        end else if (ce_in) begin
            run_command_out <= run_nxt;
            reverse_out <= run_nxt & rev_nxt;
            drive_enable_out <= run_nxt & freq_valid_in;
        end
    end

    // output terminals carrying the keypad-run-available function
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            output_terminal_out <= 3'h0;
        end else if (ce_in) begin
            output_terminal_out[0] <= (output_terminal_function_a_in == RCSS_FN_KEY_AVAIL) & key_avail;
            output_terminal_out[1] <= (output_terminal_function_b_in == RCSS_FN_KEY_AVAIL) & key_avail;
            output_terminal_out[2] <= (output_terminal_function_relay_in == RCSS_FN_KEY_AVAIL) & key_avail;
        end
    end

    // source indicator; reset shows no source until the selector is decoded
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            active_source_out <= 3'(RCSS_SEL_NONE);
        end else if (ce_in) begin
            active_source_out <= 3'(sel);
        end
    end

    a_drive_needs_freq: assert property (@(posedge clock_in) disable iff (srst_in)
        drive_enable_out |-> run_command_out && $past(freq_valid_in))
        else $error("drive enabled without frequency");
    a_key_stop: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && keypad_stop_key_in |=> !key_run_r)
        else $error("keypad stop ignored");
    a_key_dir: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_KEYPAD && !keypad_stop_key_in && keypad_run_key_in
        |=> key_run_r && key_rev_r == ($past(keypad_run_direction_in) == RCSS_DIR_REV))
        else $error("keypad direction wrong");
    a_fwdrev_both: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_TERMINAL && !stop3_assigned && fwd_in && rev_in
        && !prog_forward_in && !prog_reverse_in |=> !run_command_out)
        else $error("both directions did not stop");
    a_force_prio: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && force_key |=> active_source_out == 3'(RCSS_SEL_KEYPAD))
        else $error("force keypad lost priority");
    a_serial_only: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_SERIAL |=> run_command_out == $past(serial_run_in))
        else $error("serial run not followed");
    a_stop3_overrides: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_TERMINAL && stop3_assigned |=> run_command_out == $past(three_run))
        else $error("three-wire did not override");
    a_avail_out: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && output_terminal_function_a_in == RCSS_FN_KEY_AVAIL |=> output_terminal_out[0] == $past(key_avail))
        else $error("keypad available output wrong");
    a_avail_b: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && output_terminal_function_b_in == RCSS_FN_KEY_AVAIL |=> output_terminal_out[1] == $past(key_avail))
        else $error("keypad available output b wrong");
    a_avail_relay: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && output_terminal_function_relay_in == RCSS_FN_KEY_AVAIL
        |=> output_terminal_out[2] == $past(key_avail))
        else $error("keypad available relay wrong");
    a_key_sel: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel != RCSS_SEL_KEYPAD |=> !key_run_r)
        else $error("keypad run kept without keypad source");
    a_drive_follow: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && run_nxt && freq_valid_in |=> drive_enable_out)
        else $error("drive not enabled with run and frequency");

    // forward/reverse decode, and three-wire direction
    a_fwd_only: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_TERMINAL && !stop3_assigned && fwd_in && !rev_in && !prog_reverse_in
        |=> run_command_out && !reverse_out)
        else $error("forward only did not run forward");
    a_rev_only: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_TERMINAL && !stop3_assigned && rev_in && !fwd_in && !prog_forward_in
        |=> run_command_out && reverse_out)
        else $error("reverse only did not run reverse");
    a_neither_stop: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_TERMINAL && !stop3_assigned && !fwd_in && !rev_in
        && !prog_forward_in && !prog_reverse_in |=> !run_command_out)
        else $error("no direction did not stop");
    a_prog_fwd: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_TERMINAL && !stop3_assigned && prog_forward_in && !rev_in
        && !prog_reverse_in |=> run_command_out && !reverse_out)
        else $error("program forward not accepted");
    a_three_dir: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_TERMINAL && stop3_assigned
        |=> reverse_out == $past(three_run & (dir3 | prog_direction_in)))
        else $error("three-wire direction wrong");

    // source choice, motor copies and overrides
    a_term_src: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && !force_key && !force_term && sel_value == RCSS_SRC_TERMINAL
        |=> active_source_out == 3'(RCSS_SEL_TERMINAL))
        else $error("terminal source not taken");
    a_force_term: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && !force_key && force_term |=> active_source_out == 3'(RCSS_SEL_TERMINAL))
        else $error("force terminal ignored");
    a_motor_copy: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && !force_key && !force_term && second_motor_in && run_source_select_2nd_in == RCSS_SRC_KEYPAD
        |=> active_source_out == 3'(RCSS_SEL_KEYPAD))
        else $error("second selector copy ignored");
    a_option_src: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_OPTION |=> run_command_out == $past(option_run_in))
        else $error("option run not followed");
    a_serial_dir: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_SERIAL |=> reverse_out == $past(serial_run_in & serial_reverse_in))
        else $error("serial direction not followed");
    a_unknown_src: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && sel == RCSS_SEL_NONE
        |=> !run_command_out && active_source_out == 3'(RCSS_SEL_NONE))
        else $error("unknown source gave a run");

    // reset map and clock enable freeze
    a_reset_map: assert property (@(posedge clock_in)
        $past(srst_in) && !srst_in |-> func_r[0] == RCSS_FN_RST_T1 && func_r[1] == RCSS_FN_RST_T2)
        else $error("reset terminal map wrong");
    a_ce_freeze: assert property (@(posedge clock_in) disable iff (srst_in)
        !ce_in |=> $stable(run_command_out) && $stable(reverse_out) && $stable(drive_enable_out)
        && $stable(output_terminal_out) && $stable(active_source_out))
        else $error("outputs moved with clock enable low");

    c_key_run: cover property (@(posedge clock_in) key_run_r && drive_enable_out);
    c_term_rev: cover property (@(posedge clock_in) sel == RCSS_SEL_TERMINAL && run_command_out && reverse_out);
    c_three_run: cover property (@(posedge clock_in) three_run);
    c_force: cover property (@(posedge clock_in) force_key && force_term);
    c_avail: cover property (@(posedge clock_in) output_terminal_out != 3'h0);
endmodule : rcss_selector

// ### hdl/rcss_term_in.sv
// one input terminal: polarity correction and function match
`timescale 1ns/100ps
module rcss_term_in
    import rcss_pkg::*;
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic raw_in,
    input wire logic [7:0] function_in,
    input wire logic [7:0] polarity_in,
    output logic active_out,
    output logic [7:0] function_out
);
    logic active_nxt;

    always_comb begin
        // stop input is always read as normally closed
        if (function_in == RCSS_FN_STOP3) begin
            active_nxt = ~raw_in;
        end else if (polarity_in == RCSS_POL_NC) begin
            active_nxt = ~raw_in;
        end else begin
            active_nxt = raw_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            active_out <= 1'b0;
            function_out <= RCSS_FN_NONE;
        end else if (ce_in) begin
            active_out <= active_nxt;
            function_out <= function_in;
        end
    end
endmodule : rcss_term_in

// ### hdl/rcss_three_wire.sv
// three-wire start/stop latch with rising start edge detect
`timescale 1ns/100ps
module rcss_three_wire
    import rcss_pkg::*;
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic enable_in,
    input wire logic start_in,
    input wire logic stop_active_in,
    output logic run_out
);
    logic start_prev_r;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            start_prev_r <= 1'b0;
        end else if (ce_in) begin
            start_prev_r <= start_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            run_out <= 1'b0;
        end else if (ce_in) begin
            if (!enable_in || !stop_active_in) begin
                run_out <= 1'b0;
            end else if (start_in && !start_prev_r) begin
                run_out <= 1'b1;
            end
        end
    end

    a_start_edge: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && enable_in && stop_active_in && start_in && !start_prev_r |=> run_out)
        else $error("three-wire start edge missed");
    a_stop_drop: assert property (@(posedge clock_in) disable iff (srst_in)
        ce_in && !stop_active_in |=> !run_out)
        else $error("three-wire stop did not clear run");
endmodule : rcss_three_wire

// ### pkg/rcss_pkg.sv
// constants and types for the run command source selector
package rcss_pkg;
    localparam int RCSS_TERMS = 7;
    localparam logic [7:0] RCSS_SRC_TERMINAL = 8'h01;
    localparam logic [7:0] RCSS_SRC_KEYPAD = 8'h02;
    localparam logic [7:0] RCSS_SRC_SERIAL = 8'h03;
    localparam logic [7:0] RCSS_SRC_OPTION = 8'h04;
    localparam logic [7:0] RCSS_SRC_RESET = 8'h02;
    localparam logic [7:0] RCSS_DIR_FWD = 8'h00;
    localparam logic [7:0] RCSS_DIR_REV = 8'h01;
    localparam logic [7:0] RCSS_FN_FWD = 8'h00;
    localparam logic [7:0] RCSS_FN_REV = 8'h01;
    localparam logic [7:0] RCSS_FN_START3 = 8'h14;
    localparam logic [7:0] RCSS_FN_STOP3 = 8'h15;
    localparam logic [7:0] RCSS_FN_DIR3 = 8'h16;
    localparam logic [7:0] RCSS_FN_FORCE_KEY = 8'h1f;
    localparam logic [7:0] RCSS_FN_FORCE_TERM = 8'h33;
    localparam logic [7:0] RCSS_FN_KEY_AVAIL = 8'h3b;
    localparam logic [7:0] RCSS_FN_NONE = 8'hff;
    localparam logic [7:0] RCSS_POL_NO = 8'h00;
    localparam logic [7:0] RCSS_POL_NC = 8'h01;
    localparam logic [7:0] RCSS_FN_RST_T1 = 8'h00;
    localparam logic [7:0] RCSS_FN_RST_T2 = 8'h01;
    localparam logic [7:0] RCSS_FN_RST_OTHER = 8'hff;
    typedef enum logic [2:0] {
        RCSS_SEL_KEYPAD,
        RCSS_SEL_TERMINAL,
        RCSS_SEL_SERIAL,
        RCSS_SEL_OPTION,
        RCSS_SEL_NONE
    } rcss_sel_type;
endpackage : rcss_pkg

// ### sim/rcss_panel.sv
// operator panel model: terminal contacts, keypad keys, serial and option masters
`timescale 1ns/100ps
module rcss_panel (
    input wire logic [6:0] switch_in,
    input wire logic run_key_in,
    input wire logic stop_key_in,
    input wire logic [1:0] serial_cmd_in,
    input wire logic [1:0] option_cmd_in,
    output logic [6:0] terminal_raw_out,
    output logic run_key_out,
    output logic stop_key_out,
    output logic serial_run_out,
    output logic serial_reverse_out,
    output logic option_run_out,
    output logic option_reverse_out
);
    // contacts are wired straight through, a closed contact reads 1
    assign terminal_raw_out = switch_in;
    // keys are held levels, no debounce modelled since the block samples them itself
    assign run_key_out = run_key_in;
    assign stop_key_out = stop_key_in;
    // bus masters hand over decoded run and direction levels
    assign serial_run_out = serial_cmd_in[0];
    assign serial_reverse_out = serial_cmd_in[1];
    assign option_run_out = option_cmd_in[0];
    assign option_reverse_out = option_cmd_in[1];
endmodule : rcss_panel

// ### sim/rcss_selector_tb.sv
// self-checking testbench for the run command source selector
`timescale 1ns/100ps
module rcss_selector_tb
    import rcss_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, cfg_wr = 1'b0, second = 1'b0, freq = 1'b0;
    logic rk = 1'b0, sk = 1'b0, pf = 1'b0, ce = 1'b1;
    logic [6:0] sw = 7'h00, raw;
    logic [1:0] ser = 2'h0, opt = 2'h0;
    logic [2:0] cfg_t = 3'h0, oterm, asrc;
    logic [7:0] sel = RCSS_SRC_KEYPAD, sel2 = RCSS_SRC_KEYPAD, dir = RCSS_DIR_REV, cfg_f = 8'hff, cfg_p = 8'h00;
    logic [7:0] fa = RCSS_FN_KEY_AVAIL, fb = RCSS_FN_KEY_AVAIL;
    logic run, rev, drv, rko, sko, sr, sv, orun, orev;
    int err_count = 0, comparisons = 0, cycles = 0, i;
    always #4 clk = ~clk;
    rcss_panel panel (.switch_in(sw), .run_key_in(rk), .stop_key_in(sk), .serial_cmd_in(ser),
        .option_cmd_in(opt), .terminal_raw_out(raw), .run_key_out(rko), .stop_key_out(sko),
        .serial_run_out(sr), .serial_reverse_out(sv), .option_run_out(orun), .option_reverse_out(orev));
    rcss_selector DUT (.clock_in(clk), .srst_in(srst), .ce_in(ce), .run_source_select_in(sel),
        .run_source_select_2nd_in(sel2), .second_motor_in(second), .keypad_run_direction_in(dir),
        .keypad_run_key_in(rko), .keypad_stop_key_in(sko), .terminal_raw_in(raw), .cfg_write_in(cfg_wr),
        .cfg_terminal_in(cfg_t), .cfg_function_in(cfg_f), .cfg_polarity_in(cfg_p), .prog_forward_in(pf),
        .prog_reverse_in(1'b0), .prog_start_in(1'b0), .prog_stop_in(1'b0), .prog_direction_in(1'b0),
        .serial_run_in(sr), .serial_reverse_in(sv), .option_run_in(orun), .option_reverse_in(orev),
        .freq_valid_in(freq), .output_terminal_function_a_in(fa), .output_terminal_function_b_in(fb),
        .output_terminal_function_relay_in(8'hff), .run_command_out(run), .reverse_out(rev),
        .drive_enable_out(drv), .output_terminal_out(oterm), .active_source_out(asrc));
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // run, reverse and drive enable as one value, settled several edges after the stimulus
    task automatic chk_run(input logic r, input logic v, input logic d);
        step(4);
        chk({5'h00, run, rev, drv}, {5'h00, r, v, d});
    endtask : chk_run
    task automatic cfg(input logic [2:0] t, input logic [7:0] f, input logic [7:0] p);
        cfg_t = t;
        cfg_f = f;
        cfg_p = p;
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
        // one idle edge so back-to-back writes never retoggle the strobe in one step
        step(1);
    endtask : cfg
    // 0 run key, 1 stop key, 2 terminal 1 contact; driven directly since a copied argument never reaches the pin
    task automatic press(input int k);
        case (k)
            0: rk = 1'b1;
            1: sk = 1'b1;
            default: sw[0] = 1'b1;
        endcase
        step(2);
        case (k)
            0: rk = 1'b0;
            1: sk = 1'b0;
            default: sw[0] = 1'b0;
        endcase
    endtask : press
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        step(8);
        chk({5'h00, run, rev, drv}, 8'h00);
        chk({5'h00, asrc}, 8'h04);
        srst = 1'b0;
        step(4);
        chk({5'h00, oterm}, 8'h03);
        press(0);
        chk_run(1'b1, 1'b1, 1'b0);
        chk({5'h00, oterm}, 8'h00);
        freq = 1'b1;
        chk_run(1'b1, 1'b1, 1'b1);
        press(1);
        chk_run(1'b0, 1'b0, 1'b0);
        dir = RCSS_DIR_FWD;
        press(0);
        chk_run(1'b1, 1'b0, 1'b1);
        press(1);
        sel = RCSS_SRC_TERMINAL;
        for (i = 0; i < 4; i++) begin
            sw = 7'(i);
            chk_run(i == 1 || i == 2, i == 2, i == 1 || i == 2);
        end
        sw = 7'h00;
        cfg(3'h0, RCSS_FN_FWD, RCSS_POL_NC);
        chk_run(1'b1, 1'b0, 1'b1);
        cfg(3'h0, RCSS_FN_NONE, RCSS_POL_NO);
        cfg(3'h4, RCSS_FN_FWD, RCSS_POL_NO);
        sw = 7'h10;
        chk_run(1'b1, 1'b0, 1'b1);
        sw = 7'h00;
        pf = 1'b1;
        chk_run(1'b1, 1'b0, 1'b1);
        pf = 1'b0;
        // stop set up with open-contact polarity: it must still read as normally closed
        cfg(3'h0, RCSS_FN_START3, RCSS_POL_NO);
        cfg(3'h1, RCSS_FN_STOP3, RCSS_POL_NO);
        cfg(3'h2, RCSS_FN_DIR3, RCSS_POL_NO);
        sw = 7'h12;
        chk_run(1'b0, 1'b0, 1'b0);
        press(2);
        chk_run(1'b0, 1'b0, 1'b0);
        sw = 7'h14;
        step(1);
        press(2);
        chk_run(1'b1, 1'b1, 1'b1);
        sw[1] = 1'b1;
        chk_run(1'b0, 1'b0, 1'b0);
        sw[0] = 1'b1;
        step(2);
        sw[1] = 1'b0;
        chk_run(1'b0, 1'b0, 1'b0);
        for (i = 0; i < 5; i++) begin
            cfg(3'(i), RCSS_FN_NONE, RCSS_POL_NO);
        end
        sw = 7'h00;
        sel = RCSS_SRC_SERIAL;
        ser = 2'h3;
        chk_run(1'b1, 1'b1, 1'b1);
        chk({5'h00, asrc}, 8'h02);
        cfg(3'h5, RCSS_FN_FORCE_KEY, RCSS_POL_NO);
        cfg(3'h6, RCSS_FN_FORCE_TERM, RCSS_POL_NO);
        sw = 7'h60;
        step(4);
        chk({5'h00, asrc}, 8'h00);
        sw = 7'h40;
        step(4);
        chk({5'h00, asrc}, 8'h01);
        sw = 7'h00;
        ser = 2'h0;
        sel = RCSS_SRC_OPTION;
        opt = 2'h1;
        chk_run(1'b1, 1'b0, 1'b1);
        chk({5'h00, asrc}, 8'h03);
        // clock enable low freezes the run command even though the option drops it
        ce = 1'b0;
        opt = 2'h0;
        chk_run(1'b1, 1'b0, 1'b1);
        ce = 1'b1;
        chk_run(1'b0, 1'b0, 1'b0);
        second = 1'b1;
        step(4);
        chk({5'h00, asrc}, 8'h00);
        second = 1'b0;
        sel = 8'h07;
        chk_run(1'b0, 1'b0, 1'b0);
        chk({5'h00, asrc}, 8'h04);
        finish_test();
    end
endmodule : rcss_selector_tb
